// ==== pkg/pdu_pkg.sv ====
// Constants, field layout and state types of the DMA user-port block.
// Assumes a single system clock shared by every user of the package.
package pdu_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0] PDU_REG_MODE_LO = 4'h0;
    localparam logic [3:0] PDU_REG_MODE_HI = 4'h4;
    localparam logic [3:0] PDU_REG_STATUS = 4'h8;
    localparam logic [31:0] PDU_MODE_RST = 32'h0000_0000;
    // Status bit positions
    localparam int PDU_ST_AR = 0;
    localparam int PDU_ST_WR = 1;
    localparam int PDU_ST_RD = 2;
    localparam int PDU_ST_LEG = 3;
    // Channel constants
    localparam logic [2:0] PDU_BEAT_SIZE = 3'h6; // 64-byte beats
    localparam logic [1:0] PDU_RESP_OKAY = 2'h0;
    localparam logic [3:0] PDU_AR_CACHE = 4'h0;
    localparam logic [11:0] PDU_BEAT_ROUND = 12'h03f;
    localparam logic [5:0] PDU_ONE_BEAT = 6'h01;
    localparam int PDU_PROT_NS = 1;
    // Read sideband field positions
    localparam int PDU_SB_RID_LO = 32;
    localparam int PDU_SB_FN_LO = 24;
    localparam int PDU_SB_EOP = 23;
    localparam int PDU_SB_RSV = 22;
    localparam int PDU_SB_BC_LO = 12;
    localparam int PDU_SB_DMA = 11;
    typedef enum logic [1:0] {PDU_W_IDLE, PDU_W_DATA, PDU_W_RESP} pdu_wr_state_type;
    typedef enum logic [1:0] {PDU_R_IDLE, PDU_R_REQ, PDU_R_DATA, PDU_R_LAST} pdu_rd_state_type;

    // Beats minus one spanned by a byte run starting at a beat offset
    function automatic logic [3:0] pdu_len_of(input logic [5:0] off, input logic [9:0] bytes);
        logic [11:0] span;
        span = {6'h00, off} + {2'h0, bytes} + PDU_BEAT_ROUND;
        return 4'(span[11:6] - PDU_ONE_BEAT);
    endfunction
endpackage

// ==== hw/pdu_dma_ports.sv ====
// User-side AXI4 ports of the DMA block: read manager, write and read
// subordinates, interrupt request port and a small Avalon-MM register slave.
// Assumes all user logic runs on sys_clk; requests over 16 beats never come.
// Overview of operation
// - Read address protection uses bit 1 only; bits 2 and 0 stay zero.
// - Read sideband bits 47:32 carry the requester identifier.
// - Read sideband bits 31:24 carry the targeted function number.
// - Sideband bit 23 marks packet end for DMA sources, else always one.
// - Sideband bit 22 is reserved; bits 21:12 carry the byte count.
// - The byte count is exact, never rounded to beats.
// - Sideband bits 11:0 carry the transaction source code.
// - Read address has 4-bit id, 64-bit address, exact length, 3-bit size.
// - Write data carries one strobe bit per byte lane.
// - Request ids are 16 bits in, response ids 4 bits out.
// - Device gives a 64-bit per-vector edge/level indication.
`timescale 1ns/1ps
`default_nettype none
module pdu_dma_ports (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Avalon-MM register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // DMA read requests from the engine
    input wire logic dma_rd_valid,
    output logic dma_rd_ready,
    input wire logic [63:0] dma_rd_addr,
    input wire logic [9:0] dma_rd_bytes,
    input wire logic [11:0] dma_rd_src,
    input wire logic [7:0] dma_rd_func,
    input wire logic [15:0] dma_rd_reqid,
    input wire logic dma_rd_eop,
    input wire logic dma_rd_nonsec,
    // Manager read address
    output logic [3:0] mgr_read_id,
    output logic [63:0] mgr_read_addr,
    output logic [3:0] mgr_read_burst_length,
    output logic [2:0] mgr_read_beat_size,
    output logic [2:0] mgr_read_protection,
    output logic [3:0] mgr_read_cache,
    output logic [47:0] mgr_read_sideband,
    output logic mgr_read_valid,
    input wire logic mgr_read_ready,
    // Manager read data
    input wire logic [3:0] mgr_rdata_id,
    input wire logic [511:0] mgr_rdata,
    input wire logic [1:0] mgr_rdata_resp,
    input wire logic mgr_rdata_last,
    input wire logic mgr_rdata_valid,
    output logic mgr_rdata_ready,
    // Read data toward the engine
    output logic [3:0] dma_rdat_id,
    output logic [511:0] dma_rdat_data,
    output logic [1:0] dma_rdat_resp,
    output logic dma_rdat_last,
    output logic dma_rdat_valid,
    input wire logic dma_rdat_ready,
    // Subordinate write address, data and response
    input wire logic [15:0] sub_write_id,
    input wire logic [63:0] sub_write_addr,
    input wire logic [3:0] sub_write_burst_length,
    input wire logic [2:0] sub_write_size,
    input wire logic [2:0] sub_write_protection,
    input wire logic [3:0] sub_write_cache,
    input wire logic [7:0] sub_write_function_select,
    input wire logic sub_write_valid,
    output logic sub_write_ready,
    input wire logic [3:0] sub_write_data_tag,
    input wire logic [511:0] sub_wdata,
    input wire logic [63:0] sub_wstrb,
    input wire logic sub_wlast,
    input wire logic sub_wvalid,
    output logic sub_wready,
    output logic [3:0] sub_bresp_id,
    output logic [1:0] sub_bresp,
    output logic sub_bvalid,
    input wire logic sub_bready,
    // Write beats toward PCIe
    output logic [63:0] pcie_wr_addr,
    output logic [7:0] pcie_wr_func,
    output logic pcie_wr_nonsec,
    output logic [511:0] pcie_wr_data,
    output logic [63:0] pcie_wr_strb,
    output logic pcie_wr_last,
    output logic pcie_wr_valid,
    input wire logic pcie_wr_ready,
    // Subordinate read address and data
    input wire logic [15:0] sub_read_id,
    input wire logic [63:0] sub_read_addr,
    input wire logic [3:0] sub_read_burst_length,
    input wire logic [2:0] sub_read_size,
    input wire logic [2:0] sub_read_protection,
    input wire logic [3:0] sub_read_cache,
    input wire logic [7:0] sub_read_function_select,
    input wire logic sub_read_valid,
    output logic sub_read_ready,
    output logic [3:0] sub_rdata_id,
    output logic [511:0] sub_rdata,
    output logic [1:0] sub_rdata_resp,
    output logic sub_rdata_last,
    output logic sub_rdata_valid,
    input wire logic sub_rdata_ready,
    // Read request and completion beats on the PCIe side
    output logic [63:0] pcie_rd_addr,
    output logic [3:0] pcie_rd_len,
    output logic [7:0] pcie_rd_func,
    output logic pcie_rd_nonsec,
    output logic pcie_rd_valid,
    input wire logic pcie_rd_ready,
    input wire logic [511:0] pcie_cpl_data,
    input wire logic [1:0] pcie_cpl_resp,
    input wire logic pcie_cpl_valid,
    output logic pcie_cpl_ready,
    // Interrupts
    input wire logic [63:0] int_request,
    output logic [63:0] int_edge_level_n,
    output logic [63:0] int_msg_pulse,
    output logic int_legacy_level
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic ack_q;
    logic [63:0] mode_q;
    logic arv_q;
    logic drv_q;
    logic pwv_q;
    logic srv_q;
    logic [3:0] cnt_q;
    pdu_pkg::pdu_wr_state_type wst_q;
    pdu_pkg::pdu_rd_state_type rst_q;
    logic ld_ar;
    logic r_in;
    logic w_in;
    logic cpl_in;

    // One wait state: decode on the first cycle, answer on the second
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
            if (avs_read & ~ack_q) begin
                unique case (avs_address)
                    pdu_pkg::PDU_REG_MODE_LO: avs_readdata <= mode_q[31:0];
                    pdu_pkg::PDU_REG_MODE_HI: avs_readdata <= mode_q[63:32];
                    pdu_pkg::PDU_REG_STATUS: avs_readdata <= {28'h0000000, int_legacy_level,
                        (rst_q != pdu_pkg::PDU_R_IDLE), (wst_q != pdu_pkg::PDU_W_IDLE), arv_q};
                    default: avs_readdata <= 32'h0000_0000; // Unmapped reads as zero
                endcase
            end
        end
    end

    // Mode words take effect at the edge where waitrequest is low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= {pdu_pkg::PDU_MODE_RST, pdu_pkg::PDU_MODE_RST};
        end else if (avs_write & ack_q) begin
            if (avs_address == pdu_pkg::PDU_REG_MODE_LO) mode_q[31:0] <= avs_writedata;
            if (avs_address == pdu_pkg::PDU_REG_MODE_HI) mode_q[63:32] <= avs_writedata;
        end
    end

    // Manager read address: a skid-free holding stage
    assign ld_ar = dma_rd_valid & dma_rd_ready;
    assign dma_rd_ready = ~arv_q | mgr_read_ready;
    assign mgr_read_valid = arv_q;
    assign mgr_read_beat_size = pdu_pkg::PDU_BEAT_SIZE;
    assign mgr_read_cache = pdu_pkg::PDU_AR_CACHE;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            arv_q <= 1'b0;
            mgr_read_id <= 4'h0;
            mgr_read_addr <= 64'h0;
            mgr_read_burst_length <= 4'h0;
            mgr_read_protection <= 3'h0;
            mgr_read_sideband <= 48'h0;
        end else begin
            if (ld_ar) begin
                arv_q <= 1'b1;
                mgr_read_id <= mgr_read_id + 4'h1;
                mgr_read_addr <= dma_rd_addr;
                // Offset in the first beat adds to the span
                mgr_read_burst_length <= pdu_pkg::pdu_len_of(dma_rd_addr[5:0], dma_rd_bytes);
                mgr_read_protection <= {1'b0, dma_rd_nonsec, 1'b0};
                mgr_read_sideband <= {dma_rd_reqid, dma_rd_func,
                    (~dma_rd_src[pdu_pkg::PDU_SB_DMA] | dma_rd_eop), 1'b0,
                    dma_rd_bytes, dma_rd_src};
            end else if (mgr_read_ready) begin
                arv_q <= 1'b0;
            end
        end
    end
    a_ar_prot: assert property (ld_ar |=> mgr_read_protection == {1'b0, $past(dma_rd_nonsec), 1'b0})
        else $error("read protection wrong");
    a_sb_reqid: assert property (ld_ar |=> mgr_read_sideband[47:pdu_pkg::PDU_SB_RID_LO] == $past(dma_rd_reqid))
        else $error("requester id wrong");
    a_sb_func: assert property (ld_ar |=> mgr_read_sideband[31:pdu_pkg::PDU_SB_FN_LO] == $past(dma_rd_func))
        else $error("function number wrong");
    a_sb_eop: assert property (arv_q && !mgr_read_sideband[pdu_pkg::PDU_SB_DMA] |-> mgr_read_sideband[pdu_pkg::PDU_SB_EOP])
        else $error("end flag low for non-DMA source");
    a_sb_count: assert property (ld_ar |=> !mgr_read_sideband[pdu_pkg::PDU_SB_RSV]
        && mgr_read_sideband[21:pdu_pkg::PDU_SB_BC_LO] == $past(dma_rd_bytes)) else $error("byte count wrong");
    a_ar_hold: assert property (arv_q && !mgr_read_ready |=> arv_q && $stable(mgr_read_addr)
        && $stable(mgr_read_sideband)) else $error("read address dropped while stalled");

    // Manager read data passes through one register toward the engine
    assign r_in = mgr_rdata_valid & mgr_rdata_ready;
    assign mgr_rdata_ready = ~drv_q | dma_rdat_ready;
    assign dma_rdat_valid = drv_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            drv_q <= 1'b0;
            dma_rdat_id <= 4'h0;
            dma_rdat_data <= 512'h0;
            dma_rdat_resp <= 2'h0;
            dma_rdat_last <= 1'b0;
        end else if (r_in) begin
            drv_q <= 1'b1;
            dma_rdat_id <= mgr_rdata_id;
            dma_rdat_data <= mgr_rdata;
            dma_rdat_resp <= mgr_rdata_resp;
            dma_rdat_last <= mgr_rdata_last;
        end else if (dma_rdat_ready) begin
            drv_q <= 1'b0;
        end
    end

    // Write subordinate: one burst at a time, then a single response
    assign sub_write_ready = (wst_q == pdu_pkg::PDU_W_IDLE);
    assign sub_wready = (wst_q == pdu_pkg::PDU_W_DATA) & (~pwv_q | pcie_wr_ready);
    assign sub_bvalid = (wst_q == pdu_pkg::PDU_W_RESP);
    assign sub_bresp = pdu_pkg::PDU_RESP_OKAY;
    assign w_in = sub_wvalid & sub_wready;
    assign pcie_wr_valid = pwv_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wst_q <= pdu_pkg::PDU_W_IDLE;
        end else begin
            unique case (wst_q)
                pdu_pkg::PDU_W_IDLE: if (sub_write_valid) wst_q <= pdu_pkg::PDU_W_DATA;
                pdu_pkg::PDU_W_DATA: if (w_in && sub_wlast) wst_q <= pdu_pkg::PDU_W_RESP;
                pdu_pkg::PDU_W_RESP: if (sub_bready) wst_q <= pdu_pkg::PDU_W_IDLE;
            endcase
        end
    end

    // Burst header; only protection bit 1 is looked at
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_bresp_id <= 4'h0;
            pcie_wr_addr <= 64'h0;
            pcie_wr_func <= 8'h00;
            pcie_wr_nonsec <= 1'b0;
        end else if (sub_write_valid && sub_write_ready) begin
            sub_bresp_id <= sub_write_id[3:0];
            pcie_wr_addr <= sub_write_addr;
            pcie_wr_func <= sub_write_function_select;
            pcie_wr_nonsec <= sub_write_protection[pdu_pkg::PDU_PROT_NS];
        end
    end
    a_bid_narrow: assert property (sub_write_valid && sub_write_ready |=> sub_bresp_id == 4'($past(sub_write_id)))
        else $error("write response id wrong");

    // Write beats toward PCIe, strobes kept with their data
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwv_q <= 1'b0;
            pcie_wr_data <= 512'h0;
            pcie_wr_strb <= 64'h0;
            pcie_wr_last <= 1'b0;
        end else if (w_in) begin
            pwv_q <= 1'b1;
            pcie_wr_data <= sub_wdata;
            pcie_wr_strb <= sub_wstrb;
            pcie_wr_last <= sub_wlast;
        end else if (pcie_wr_ready) begin
            pwv_q <= 1'b0;
        end
    end
    a_wstrb_lane: assert property (w_in |=> pcie_wr_valid && pcie_wr_strb == $past(sub_wstrb))
        else $error("strobes lost");

    // Read subordinate: forward request, then count completion beats
    assign sub_read_ready = (rst_q == pdu_pkg::PDU_R_IDLE);
    assign pcie_rd_valid = (rst_q == pdu_pkg::PDU_R_REQ);
    assign pcie_cpl_ready = (rst_q == pdu_pkg::PDU_R_DATA) & (~srv_q | sub_rdata_ready);
    assign cpl_in = pcie_cpl_valid & pcie_cpl_ready;
    assign sub_rdata_valid = srv_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= pdu_pkg::PDU_R_IDLE;
        end else begin
            unique case (rst_q)
                pdu_pkg::PDU_R_IDLE: if (sub_read_valid) rst_q <= pdu_pkg::PDU_R_REQ;
                pdu_pkg::PDU_R_REQ: if (pcie_rd_ready) rst_q <= pdu_pkg::PDU_R_DATA;
                pdu_pkg::PDU_R_DATA: if (cpl_in && cnt_q == 4'h0) rst_q <= pdu_pkg::PDU_R_LAST;
                pdu_pkg::PDU_R_LAST: if (sub_rdata_ready) rst_q <= pdu_pkg::PDU_R_IDLE;
            endcase
        end
    end

    // Request header and beat counter
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h0;
            sub_rdata_id <= 4'h0;
            pcie_rd_addr <= 64'h0;
            pcie_rd_len <= 4'h0;
            pcie_rd_func <= 8'h00;
            pcie_rd_nonsec <= 1'b0;
        end else if (sub_read_valid && sub_read_ready) begin
            cnt_q <= sub_read_burst_length;
            sub_rdata_id <= sub_read_id[3:0];
            pcie_rd_addr <= sub_read_addr;
            pcie_rd_len <= sub_read_burst_length;
            pcie_rd_func <= sub_read_function_select;
            pcie_rd_nonsec <= sub_read_protection[pdu_pkg::PDU_PROT_NS];
        end else if (cpl_in) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // Read beats toward the user, last flag made from the count
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            srv_q <= 1'b0;
            sub_rdata <= 512'h0;
            sub_rdata_resp <= 2'h0;
            sub_rdata_last <= 1'b0;
        end else if (cpl_in) begin
            srv_q <= 1'b1;
            sub_rdata <= pcie_cpl_data;
            sub_rdata_resp <= pcie_cpl_resp;
            sub_rdata_last <= (cnt_q == 4'h0);
        end else if (sub_rdata_ready) begin
            srv_q <= 1'b0;
        end
    end
    sequence s_last_cpl;
        cpl_in && cnt_q == 4'h0;
    endsequence
    sequence s_last_out;
        sub_rdata_valid && sub_rdata_last;
    endsequence
    a_rd_last_beat: assert property (s_last_cpl |=> s_last_out)
        else $error("last beat not flagged");
    a_rd_hold: assert property (srv_q && !sub_rdata_ready |=> srv_q && $stable(sub_rdata))
        else $error("read data dropped while stalled");

    // Interrupts: edge vectors drive the message output, registered, while requested; level vectors merge
    assign int_edge_level_n = mode_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_msg_pulse <= 64'h0;
            int_legacy_level <= 1'b0;
        end else begin
            int_msg_pulse <= int_request & mode_q;
            int_legacy_level <= |(int_request & ~mode_q);
        end
    end
    a_int_route: assert property (1'b1 |=> int_msg_pulse == ($past(int_request) & $past(int_edge_level_n)))
        else $error("edge request not routed");
endmodule // pdu_dma_ports
`default_nettype wire

// ==== bench/pdu_user_mem.sv ====
// User memory model behind the manager read channel of the DMA ports.
// Assumes one clock; slow lets it take an address only every other cycle.
`timescale 1ns/1ps
`default_nettype none
module pdu_user_mem (
    // Clock, reset, pacing
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic slow,
    // Read address
    input wire logic [3:0] mgr_read_id,
    input wire logic [3:0] mgr_read_burst_length,
    input wire logic mgr_read_valid,
    output logic mgr_read_ready,
    // Read data
    output logic [3:0] mgr_rdata_id,
    output logic [511:0] mgr_rdata,
    output logic [1:0] mgr_rdata_resp,
    output logic mgr_rdata_last,
    output logic mgr_rdata_valid,
    input wire logic mgr_rdata_ready
);
    logic busy_q;
    logic tick_q;
    logic [3:0] left_q;
    // One burst in flight keeps the beat count exact
    assign mgr_read_ready = !busy_q && !(slow && tick_q);
    assign mgr_rdata_resp = pdu_pkg::PDU_RESP_OKAY;
    // Beats stand until taken; released data flips so stale values never match
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            tick_q <= 1'b0;
            left_q <= 4'h0;
            mgr_rdata_valid <= 1'b0;
            mgr_rdata_last <= 1'b0;
            mgr_rdata_id <= 4'h0;
            mgr_rdata <= '0;
        end else begin
            tick_q <= !tick_q;
            if (mgr_read_valid && mgr_read_ready) begin
                busy_q <= 1'b1;
                left_q <= mgr_read_burst_length;
                mgr_rdata_valid <= 1'b1;
                mgr_rdata_last <= (mgr_read_burst_length == 4'h0);
                mgr_rdata_id <= mgr_read_id;
                mgr_rdata <= 512'(mgr_read_burst_length);
            end else if (mgr_rdata_valid && mgr_rdata_ready) begin
                left_q <= left_q - 4'h1;
                mgr_rdata_last <= (left_q == 4'h1);
                mgr_rdata <= mgr_rdata_last ? ~mgr_rdata : mgr_rdata + 512'h1;
                mgr_rdata_valid <= !mgr_rdata_last;
                busy_q <= !mgr_rdata_last;
            end
        end
    end
endmodule // pdu_user_mem
`default_nettype wire

// ==== bench/pdu_dma_ports_tb.sv ====
// Self-checking bench of the DMA user ports: registers, manager reads,
// subordinate write and read, interrupts. Assumes pdu_pkg compiled first.
`timescale 1ns/1ps
`default_nettype none
module pdu_dma_ports_tb;
    // Clock, reset, pacing
    logic sys_clk = 1'b0, reset_n = 1'b0, slow = 1'b0, pcie_cpl_valid = 1'b0;
    // Single bits, plus the 4-bit tk and sub_write_data_tag
    logic avs_read = 1'b0, avs_write = 1'b0, dma_rd_valid = 1'b0, dma_rd_eop = 1'b0, dma_rd_nonsec = 1'b0;
    logic dma_rdat_ready = 1'b1, sub_write_valid = 1'b0, sub_wlast = 1'b0, sub_wvalid = 1'b0, sub_read_valid = 1'b0;
    logic [3:0] tk = 4'h0, sub_write_data_tag = 4'h0;
    logic avs_waitrequest, dma_rd_ready, mgr_read_valid, mgr_read_ready, mgr_rdata_ready, mgr_rdata_last;
    logic mgr_rdata_valid, dma_rdat_last, dma_rdat_valid, sub_write_ready, sub_wready, sub_bvalid, pcie_wr_nonsec;
    logic pcie_wr_last, pcie_wr_valid, sub_read_ready, sub_rdata_last, sub_rdata_valid, pcie_rd_nonsec;
    logic pcie_rd_valid, pcie_cpl_ready, int_legacy_level;
    // Fields
    logic [1:0] pcie_cpl_resp = 2'h0, mgr_rdata_resp, dma_rdat_resp, sub_bresp, sub_rdata_resp;
    logic [2:0] sub_write_size = 3'h0, sub_write_protection = 3'h0, sub_read_size = 3'h0, sub_read_protection = 3'h0;
    logic [2:0] mgr_read_beat_size, mgr_read_protection;
    logic [3:0] avs_address = 4'h0, sub_write_burst_length = 4'h0, sub_write_cache = 4'h0;
    logic [3:0] sub_read_burst_length = 4'h0, sub_read_cache = 4'h0, mgr_read_id, mgr_read_burst_length;
    logic [3:0] mgr_read_cache, mgr_rdata_id, dma_rdat_id, sub_bresp_id, sub_rdata_id, pcie_rd_len;
    logic [7:0] dma_rd_func = 8'h0, sub_write_function_select = 8'h0, sub_read_function_select = 8'h0;
    logic [7:0] pcie_wr_func, pcie_rd_func;
    logic [9:0] dma_rd_bytes = 10'h0;
    logic [11:0] dma_rd_src = 12'h0;
    logic [15:0] dma_rd_reqid = 16'h0, sub_write_id = 16'h0, sub_read_id = 16'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [47:0] mgr_read_sideband;
    logic [63:0] dma_rd_addr = '0, sub_write_addr = '0, sub_wstrb = '0, sub_read_addr = '0, int_request = '0;
    logic [63:0] mgr_read_addr, pcie_wr_addr, pcie_wr_strb, pcie_rd_addr, int_edge_level_n, int_msg_pulse;
    logic [511:0] sub_wdata = '0, pcie_cpl_data = '0, mgr_rdata, dma_rdat_data, pcie_wr_data, sub_rdata;
    wire pcie_wr_ready = tk[0], pcie_rd_ready = tk[1], sub_rdata_ready = tk[2], sub_bready = tk[3];
    int err_total = 0, total_checks = 0;
    pdu_dma_ports dut (.*);
    pdu_user_mem mem (.*);
    // Clock; engine read sink stalls every other cycle when slow
    always #20 sys_clk = !sys_clk;
    always @(posedge sys_clk) dma_rdat_ready <= !slow || !dma_rdat_ready;
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Settled level seen at a falling edge; bounded so a hang ends the run
    task automatic waitv(ref logic s, input logic v);
        for (int i = 0; i < 400; i++) begin
            @(negedge sys_clk);
            if (s === v) return;
        end
        chk("timeout", 64'h0, 64'h1);
        finish_test();
    endtask
    // Ready high for exactly one rising edge
    task automatic take(input int k);
        @(posedge sys_clk);
        tk[k] <= 1'b1;
        @(posedge sys_clk);
        tk[k] <= 1'b0;
    endtask
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        waitv(avs_waitrequest, 1'b0);
        @(posedge sys_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // One engine read: address fields, sideband, then the beats of the burst
    task automatic mrd(input logic [63:0] a, input logic [9:0] n, input logic [11:0] s, input logic e,
                       input logic ns, input logic [3:0] id);
        logic [3:0] len;
        int beats = 0;
        len = 4'((int'(a[5:0]) + int'(n) + 63) / 64 - 1);
        @(posedge sys_clk);
        {dma_rd_addr, dma_rd_bytes, dma_rd_src, dma_rd_eop, dma_rd_nonsec} <= {a, n, s, e, ns};
        {dma_rd_func, dma_rd_reqid, dma_rd_valid} <= {8'h3c, 16'h5a21, 1'b1};
        waitv(dma_rd_ready, 1'b1);
        @(posedge sys_clk);
        dma_rd_valid <= 1'b0;
        waitv(mgr_read_valid, 1'b1);
        chk("ar_id_len_size", {mgr_read_id, mgr_read_burst_length, mgr_read_beat_size}, {id, len, 3'h6});
        chk("ar_addr", mgr_read_addr, a);
        chk("ar_prot", mgr_read_protection, {1'b0, ns, 1'b0});
        chk("sb_reqid", mgr_read_sideband[47:32], 16'h5a21);
        chk("sb_func", mgr_read_sideband[31:24], 8'h3c);
        chk("sb_eop", mgr_read_sideband[23], s[11] ? e : 1'b1);
        chk("sb_count", mgr_read_sideband[21:12], n);
        chk("sb_src", mgr_read_sideband[11:0], s);
        for (int i = 0; i < 80; i++) begin
            @(negedge sys_clk);
            if (dma_rdat_valid === 1'b1 && dma_rdat_ready === 1'b1) begin
                beats++;
                chk("r_id", dma_rdat_id, id);
                if (dma_rdat_last === 1'b1) break;
            end
        end
        chk("r_beats", beats, len + 1);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Register reset values, unmapped place included
        for (int a = 0; a < 16; a += 4) begin
            avs(1'b0, 4'(a), 32'h0, q);
            chk("reg_reset", q, 32'h0);
        end
        avs(1'b1, 4'h0, 32'h0000_0001, q);
        avs(1'b1, 4'h4, 32'h8000_0000, q);
        avs(1'b1, 4'hc, 32'hffff_ffff, q);
        avs(1'b0, 4'h4, 32'h0, q);
        chk("mode_hi", q, 32'h8000_0000);
        avs(1'b0, 4'hc, 32'h0, q);
        chk("unmapped", q, 32'h0);
        chk("edge_level", int_edge_level_n, 64'h8000_0000_0000_0001);
        // Edge vector pulses once; level vector held while pending
        @(posedge sys_clk);
        int_request <= 64'h1;
        @(posedge sys_clk);
        int_request <= 64'h20;
        @(negedge sys_clk);
        chk("msg_pulse", int_msg_pulse, 64'h1);
        repeat (3) @(negedge sys_clk);
        chk("pulse_once_legacy", {int_msg_pulse[62:0], int_legacy_level}, 64'h1);
        @(posedge sys_clk);
        int_request <= 64'h0;
        repeat (2) @(negedge sys_clk);
        chk("legacy_clear", int_legacy_level, 1'b0);
        // Engine reads: two-beat DMA, sixteen-beat stalled, single-beat packet end
        mrd(64'h0000_0001_0000_0010, 10'd100, 12'h803, 1'b0, 1'b1, 4'h1);
        @(posedge sys_clk);
        slow <= 1'b1;
        mrd(64'h0000_0000_2000_0000, 10'd1000, 12'h005, 1'b0, 1'b0, 4'h2);
        mrd(64'h0000_0000_0000_0040, 10'd64, 12'hfff, 1'b1, 1'b1, 4'h3);
        // Subordinate write of two beats, PCIe side stalling
        @(posedge sys_clk);
        {sub_write_id, sub_write_addr, sub_write_burst_length} <= {16'hbeef, 64'h8000_1000, 4'h1};
        {sub_write_size, sub_write_protection, sub_write_function_select} <= {3'h6, 3'h2, 8'h07};
        sub_write_valid <= 1'b1;
        waitv(sub_write_ready, 1'b1);
        @(posedge sys_clk);
        sub_write_valid <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            {sub_wdata, sub_wstrb, sub_wlast, sub_wvalid} <= {512'(64'ha00 + i), 64'hff << (8 * i), i == 1, 1'b1};
            waitv(sub_wready, 1'b1);
            @(posedge sys_clk);
            sub_wvalid <= 1'b0;
            waitv(pcie_wr_valid, 1'b1);
            chk("w_data", pcie_wr_data[63:0], 64'ha00 + i);
            chk("w_strb", pcie_wr_strb, 64'hff << (8 * i));
            chk("w_ctl", {pcie_wr_last, pcie_wr_nonsec, pcie_wr_func}, {i == 1, 9'h107});
            chk("w_addr", pcie_wr_addr, 64'h8000_1000);
            take(0);
        end
        waitv(sub_bvalid, 1'b1);
        chk("b_id_resp", {sub_bresp_id, sub_bresp}, {4'hf, pdu_pkg::PDU_RESP_OKAY});
        take(3);
        // Subordinate read of two beats, user side stalling
        {sub_read_id, sub_read_addr, sub_read_burst_length} <= {16'h00a3, 64'h9000_0040, 4'h1};
        {sub_read_size, sub_read_protection, sub_read_function_select} <= {3'h6, 3'h2, 8'h09};
        sub_read_valid <= 1'b1;
        waitv(sub_read_ready, 1'b1);
        @(posedge sys_clk);
        sub_read_valid <= 1'b0;
        waitv(pcie_rd_valid, 1'b1);
        chk("rd_req", {pcie_rd_nonsec, pcie_rd_func, pcie_rd_len}, 13'h1091);
        chk("rd_addr", pcie_rd_addr, 64'h9000_0040);
        take(1);
        for (int i = 0; i < 2; i++) begin
            {pcie_cpl_data, pcie_cpl_valid} <= {512'(64'hc0 + i), 1'b1};
            waitv(pcie_cpl_ready, 1'b1);
            @(posedge sys_clk);
            pcie_cpl_valid <= 1'b0;
            waitv(sub_rdata_valid, 1'b1);
            chk("rd_beat", {sub_rdata_last, sub_rdata_id, sub_rdata[7:0]}, {i == 1, 4'h3, 8'(8'hc0 + i)});
            take(2);
        end
        finish_test();
    end
endmodule // pdu_dma_ports_tb
`default_nettype wire
